// file: ucsi_pkg.sv
// Package for the USB control, status and event block.
// Assumes a 32-bit APB slave at 200 MHz, one clock domain.
`default_nettype none
package ucsi_pkg;
	// Register byte offsets
	localparam logic [7:0] CSR0_OFS = 8'h00;
	localparam logic [7:0] EVT_OFS = 8'h04;
	localparam logic [7:0] CFG_OFS = 8'h08;
	// Control/status register 0 field positions
	localparam int RESUME_BIT = 10;
	localparam int SUSP_STAT_BIT = 9;
	localparam int SUSP_ALLOW_BIT = 8;
	localparam int ADDR_LSB = 0;
	localparam int ADDR_W = 7;
	// Event register field positions
	localparam int EN_LSB = 24;
	localparam int FLAG_LSB = 16;
	localparam int NUM_EVT = 8;
	// Configuration register: role select
	localparam int HOST_ROLE_BIT = 0;
	// Reset values
	localparam logic [7:0] EN_RESET = 8'h06;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [6:0] ADDR_RESET = 7'h00;
	localparam logic SUSP_ALLOW_RESET = 1'b0;
	// Event indices in enable/flag order, bit 7 down to bit 0
	localparam int EV_VBUS = 7;
	localparam int EV_SESS = 6;
	localparam int EV_DISC = 5;
	localparam int EV_CONN = 4;
	localparam int EV_SOF = 3;
	localparam int EV_RSTB = 2;
	localparam int EV_RES = 1;
	localparam int EV_SUSP = 0;
	// Bus-side event inputs as they arrive from the link logic
	typedef struct packed {
		logic vbus_low;
		logic session_active;
		logic session_request;
		logic dev_detached;
		logic dev_attached;
		logic frame_start;
		logic reset_babble;
		logic resume_seen;
		logic idle_seen;
		logic wake_seen;
	} ucsi_line_t;
	// Token address check
	typedef struct packed {
		logic valid;
		logic [6:0] addr;
	} ucsi_token_t;
endpackage : ucsi_pkg
`default_nettype wire

// file: ucsi_core.sv
// USB control, status and event-latch block with an APB slave.
// Assumes line events arrive from the link logic on the same clock.
//
// Functional notes
// R1 - While suspended and the resume bit is set, resume signalling is driven until the bit is cleared.
// R2 - Device-role software clears the resume bit about 10 ms after setting it, at most 15 ms.
// R3 - Host-role software clears the resume bit 20 ms after setting it.
// R4 - The suspend status bit reads one while suspended and zero otherwise.
// R5 - Suspend status writes are ignored in device role; host software may set it, hardware clears it.
// R6 - Suspend is entered only while the suspend allow bit is one.
// R7 - In device role the 7-bit address field is compared with every token address.
// R8 - The VBUS error flag sets when VBUS drops below valid during a session.
// R9 - The session request flag sets on detected session request signalling.
// R10 - The disconnect flag sets on detach in host role and on session end in device role.
// R11 - In host role the connect flag sets when a device attaches.
// R12 - One enable, reset to one, gates bus reset in device role and babble in host role.
// R13 - Enables sit in bits 31..24 and flags in 23..16, in the same event order.
// R14 - The interrupt is high while any flag is set with its enable one; flags hold until cleared.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`default_nettype none
module ucsi_core (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire ucsi_pkg::ucsi_line_t line_i,
	input wire ucsi_pkg::ucsi_token_t token_i,
	output logic addr_match_o,
	output logic resume_drive_o,
	output logic suspended_o,
	output logic host_role_o,
	output logic irq_o
);
	logic resume_reg;
	logic suspended_status_reg;
	logic suspend_allow_reg;
	logic [6:0] device_address_field_reg;
	logic [7:0] evt_enable_reg;
	logic [7:0] evt_flag_reg;
	logic [7:0] evt_set;
	logic host_reg;
	logic sess_prev_reg;
	logic match_reg;
	logic wr_en;
	logic rd_en;
	logic hit_csr0;
	logic hit_evt;
	logic hit_cfg;
	logic wake_any;
	logic [7:0] flags_read;

	// Register map, one 32-bit word per byte offset:
	//   0x00 control/status: resume 10, suspend 9, allow 8, address 6..0
	//   0x04 events: enables 31..24, sticky flags 23..16, same order
	//   0x08 configuration: bit 0 selects the host role
	// Read data is taken in the setup cycle, so an event may land between
	// the capture and the access; the flag logic below allows for that.

	////////////////////////////////////////////////////////////////////
	// APB decode; single-cycle access, never waits
	assign wr_en = psel_i & penable_i & pwrite_i;
	assign rd_en = psel_i & penable_i & ~pwrite_i;
	assign hit_csr0 = (paddr_i == ucsi_pkg::CSR0_OFS);
	assign hit_evt = (paddr_i == ucsi_pkg::EVT_OFS);
	assign hit_cfg = (paddr_i == ucsi_pkg::CFG_OFS);
	assign pready_o = 1'b1;
	// Unmapped addresses answer with an error so firmware bugs show up
	assign pslverr_o = psel_i & penable_i & ~(hit_csr0 | hit_evt | hit_cfg);

	// Read data is registered on the setup cycle and valid in access
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			prdata_o <= 32'h0000_0000;
			if (hit_csr0) begin
				prdata_o[ucsi_pkg::RESUME_BIT] <= resume_reg;
				prdata_o[ucsi_pkg::SUSP_STAT_BIT] <= suspended_status_reg; // [R4]
				prdata_o[ucsi_pkg::SUSP_ALLOW_BIT] <= suspend_allow_reg;
				prdata_o[ucsi_pkg::ADDR_LSB +: ucsi_pkg::ADDR_W] <=
					device_address_field_reg;
			end else if (hit_evt) begin
				prdata_o[ucsi_pkg::EN_LSB +: ucsi_pkg::NUM_EVT] <=
					evt_enable_reg; // [R13]
				prdata_o[ucsi_pkg::FLAG_LSB +: ucsi_pkg::NUM_EVT] <=
					evt_flag_reg; // [R13]
			end else if (hit_cfg) begin
				prdata_o[ucsi_pkg::HOST_ROLE_BIT] <= host_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Role select, resume control, suspend allow and address field
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			host_reg <= 1'b0;
			resume_reg <= 1'b0;
			suspend_allow_reg <= ucsi_pkg::SUSP_ALLOW_RESET;
			device_address_field_reg <= ucsi_pkg::ADDR_RESET;
		end else if (wr_en && hit_cfg) begin
			host_reg <= pwdata_i[ucsi_pkg::HOST_ROLE_BIT];
		end else if (wr_en && hit_csr0) begin
			// Timing of the clear is left to software [R2] [R3]
			resume_reg <= pwdata_i[ucsi_pkg::RESUME_BIT];
			suspend_allow_reg <= pwdata_i[ucsi_pkg::SUSP_ALLOW_BIT];
			device_address_field_reg <=
				pwdata_i[ucsi_pkg::ADDR_LSB +: ucsi_pkg::ADDR_W];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Any bus traffic that must end suspend; it outranks every set
	assign wake_any = line_i.wake_seen | line_i.resume_seen
		| line_i.reset_babble;

	// Suspend state; hardware leaves suspend on wake or resume traffic
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			suspended_status_reg <= 1'b0;
		end else if (wake_any) begin
			suspended_status_reg <= 1'b0; // [R5]
		end else if (!suspend_allow_reg) begin
			suspended_status_reg <= 1'b0; // [R6]
		end else if (line_i.idle_seen) begin
			suspended_status_reg <= 1'b1; // [R6]
		end else if (wr_en && hit_csr0 && host_reg
			&& pwdata_i[ucsi_pkg::SUSP_STAT_BIT]) begin
			// Device-role writes fall through and change nothing
			suspended_status_reg <= 1'b1; // [R5]
		end
	end
	assign suspended_o = suspended_status_reg; // [R4]
	// Resume drive only while suspended, stops as soon as bit clears
	assign resume_drive_o = resume_reg & suspended_status_reg; // [R1]
	assign host_role_o = host_reg;

	////////////////////////////////////////////////////////////////////
	// Token address compare, registered; host role never matches
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			match_reg <= 1'b0;
		end else begin
			match_reg <= token_i.valid & ~host_reg
				& (token_i.addr == device_address_field_reg); // [R7]
		end
	end
	assign addr_match_o = match_reg;

	////////////////////////////////////////////////////////////////////
	// Session tracking for end-of-session detection in device role
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sess_prev_reg <= 1'b0;
		end else begin
			sess_prev_reg <= line_i.session_active;
		end
	end

	// Event sources in enable/flag order
	always_comb begin
		evt_set = 8'h00;
		evt_set[ucsi_pkg::EV_VBUS] = line_i.vbus_low
			& line_i.session_active; // [R8]
		evt_set[ucsi_pkg::EV_SESS] = line_i.session_request; // [R9]
		evt_set[ucsi_pkg::EV_DISC] = host_reg ? line_i.dev_detached
			: (sess_prev_reg & ~line_i.session_active); // [R10]
		evt_set[ucsi_pkg::EV_CONN] = host_reg & line_i.dev_attached; // [R11]
		evt_set[ucsi_pkg::EV_SOF] = line_i.frame_start;
		// Same input means bus reset as device, babble as host [R12]
		evt_set[ucsi_pkg::EV_RSTB] = line_i.reset_babble;
		evt_set[ucsi_pkg::EV_RES] = line_i.resume_seen & suspended_status_reg;
		evt_set[ucsi_pkg::EV_SUSP] = line_i.idle_seen & suspend_allow_reg
			& ~suspended_status_reg;
	end

	////////////////////////////////////////////////////////////////////
	// Enables: written by software, reset value has bits 26 and 25 set
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			evt_enable_reg <= ucsi_pkg::EN_RESET; // [R12]
		end else if (wr_en && hit_evt) begin
			evt_enable_reg <= pwdata_i[ucsi_pkg::EN_LSB +: ucsi_pkg::NUM_EVT];
		end
	end

	// Flag field of the word that the pending read returns
	assign flags_read = prdata_o[ucsi_pkg::FLAG_LSB +: ucsi_pkg::NUM_EVT];

	// Sticky flags; a read clears only the flags that it returned, so an
	// event caught after the setup capture waits for the next read
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			evt_flag_reg <= ucsi_pkg::FLAG_RESET;
		end else if (rd_en && hit_evt) begin
			// A new event in the same cycle wins over the clear
			evt_flag_reg <= (evt_flag_reg & ~flags_read) | evt_set; // [R14]
		end else begin
			evt_flag_reg <= evt_flag_reg | evt_set; // [R14]
		end
	end

	// Level interrupt from unmasked flags
	assign irq_o = |(evt_flag_reg & evt_enable_reg); // [R14]

	////////////////////////////////////////////////////////////////////
	// Assertions
	sequence s_flag_set(int i);
		evt_set[i] ##1 evt_flag_reg[i];
	endsequence

	// A full read of the event register: setup cycle, then access
	sequence s_evt_read;
		psel_i && !penable_i && !pwrite_i && hit_evt
		##1 rd_en && hit_evt;
	endsequence

	resume_drive_a: assert property ( // [R1]
		@(posedge clk_i) disable iff (!rst_n_i)
		resume_drive_o |-> resume_reg && suspended_status_reg)
		else $error("resume driven without bit or suspend");

	resume_stop_a: assert property ( // [R1]
		@(posedge clk_i) disable iff (!rst_n_i)
		$fell(resume_reg) |-> !resume_drive_o)
		else $error("resume kept after clear");

	susp_block_a: assert property ( // [R6]
		@(posedge clk_i) disable iff (!rst_n_i)
		!suspend_allow_reg |=> !suspended_status_reg)
		else $error("suspend entered while not allowed");

	susp_enter_a: assert property ( // [R6]
		@(posedge clk_i) disable iff (!rst_n_i)
		(suspend_allow_reg && line_i.idle_seen && !wake_any)
		|=> suspended_status_reg)
		else $error("idle bus did not suspend");

	susp_exit_a: assert property ( // [R5]
		@(posedge clk_i) disable iff (!rst_n_i)
		wake_any |=> !suspended_status_reg)
		else $error("suspend kept after wake traffic");

	susp_devwr_a: assert property ( // [R5]
		@(posedge clk_i) disable iff (!rst_n_i)
		(wr_en && hit_csr0 && !host_reg && !suspended_status_reg
		&& !line_i.idle_seen) |=> !suspended_status_reg)
		else $error("device write changed suspend state");

	host_set_a: assert property ( // [R5]
		@(posedge clk_i) disable iff (!rst_n_i)
		(wr_en && hit_csr0 && host_reg && suspend_allow_reg && !wake_any
		&& pwdata_i[ucsi_pkg::SUSP_STAT_BIT]) |=> suspended_status_reg)
		else $error("host write did not suspend");

	susp_read_a: assert property ( // [R4]
		@(posedge clk_i) disable iff (!rst_n_i)
		(psel_i && !penable_i && !pwrite_i && hit_csr0) |=>
		prdata_o[ucsi_pkg::SUSP_STAT_BIT] == $past(suspended_status_reg))
		else $error("suspend status readback wrong");

	addr_match_a: assert property ( // [R7]
		@(posedge clk_i) disable iff (!rst_n_i)
		(token_i.valid && !host_reg
		&& token_i.addr == device_address_field_reg) |=> addr_match_o)
		else $error("token address not matched");

	addr_miss_a: assert property ( // [R7]
		@(posedge clk_i) disable iff (!rst_n_i)
		(!token_i.valid || host_reg
		|| token_i.addr != device_address_field_reg) |=> !addr_match_o)
		else $error("foreign token address matched");

	vbus_flag_a: assert property ( // [R8]
		@(posedge clk_i) disable iff (!rst_n_i)
		(line_i.vbus_low && line_i.session_active) |-> s_flag_set(7))
		else $error("vbus error flag not set");

	sess_flag_a: assert property ( // [R9]
		@(posedge clk_i) disable iff (!rst_n_i)
		line_i.session_request |-> s_flag_set(6))
		else $error("session request flag not set");

	conn_flag_a: assert property ( // [R11]
		@(posedge clk_i) disable iff (!rst_n_i)
		(host_reg && line_i.dev_attached) |=> evt_flag_reg[4])
		else $error("connect flag not set");

	disc_flag_a: assert property ( // [R10]
		@(posedge clk_i) disable iff (!rst_n_i)
		(!host_reg && $fell(line_i.session_active)) |-> evt_flag_reg[5]
		or ##1 evt_flag_reg[5])
		else $error("session end not flagged");

	host_disc_a: assert property ( // [R10]
		@(posedge clk_i) disable iff (!rst_n_i)
		(host_reg && line_i.dev_detached) |-> s_flag_set(5))
		else $error("detach not flagged");

	sof_flag_a: assert property ( // [R13]
		@(posedge clk_i) disable iff (!rst_n_i)
		line_i.frame_start |-> s_flag_set(3))
		else $error("frame start flag not set");

	rstb_flag_a: assert property ( // [R12]
		@(posedge clk_i) disable iff (!rst_n_i)
		line_i.reset_babble |-> s_flag_set(2))
		else $error("reset or babble flag not set");

	rstb_reset_a: assert property ( // [R12]
		@(posedge clk_i)
		!rst_n_i |=> evt_enable_reg[2] && evt_enable_reg[1])
		else $error("enable reset value wrong");

	irq_level_a: assert property ( // [R14]
		@(posedge clk_i) disable iff (!rst_n_i)
		irq_o == |(evt_flag_reg & evt_enable_reg))
		else $error("interrupt does not follow flags");

	irq_hold_a: assert property ( // [R14]
		@(posedge clk_i) disable iff (!rst_n_i)
		(irq_o && !(rd_en && hit_evt) && !(wr_en && hit_evt))
		|=> irq_o)
		else $error("interrupt dropped without read or mask");

	flag_hold_a: assert property ( // [R14]
		@(posedge clk_i) disable iff (!rst_n_i)
		(evt_flag_reg[3] && !(rd_en && hit_evt)) |=> evt_flag_reg[3])
		else $error("flag dropped without read");

	flag_clear_a: assert property ( // [R14]
		@(posedge clk_i) disable iff (!rst_n_i)
		s_evt_read |=> (evt_flag_reg & $past(flags_read)
		& ~$past(evt_set)) == 8'h00)
		else $error("reported flag not cleared by read");

	set_wins_a: assert property ( // [R14]
		@(posedge clk_i) disable iff (!rst_n_i)
		s_evt_read |=> (evt_flag_reg & $past(evt_set))
		== $past(evt_set))
		else $error("event lost in read cycle");
endmodule : ucsi_core
`default_nettype wire

// file: ucsi_cable_model.sv
// Far side of the USB cable: line events and tokens.
// Assumes the bench calls its tasks from one process.
`default_nettype none
module ucsi_cable_model (
	input wire logic clk_i,
	output var ucsi_pkg::ucsi_line_t line_o,
	output var ucsi_pkg::ucsi_token_t token_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		line_o = '0;
		token_o = '0;
	end
	// One-cycle event on bit b of the line struct
	task automatic pulse(input int b);
		@(posedge clk_i);
		line_o[b] <= 1'b1;
		@(posedge clk_i);
		line_o[b] <= 1'b0;
	endtask : pulse
	// Session and VBUS are levels held until changed
	task automatic level(input int b, input logic v);
		@(posedge clk_i);
		line_o[b] <= v;
	endtask : level
	// Token; the address is scrambled once valid drops
	task automatic token(input logic [6:0] a);
		@(posedge clk_i);
		token_o <= {1'b1, a};
		@(posedge clk_i);
		token_o <= {1'b0, ~a};
	endtask : token
endmodule : ucsi_cable_model
`default_nettype wire

// file: tb_usb_core_ctrl_status_irq.sv
// Bench for the USB control, status and event block.
// Waits on pready, so any APB wait count works; assumes a 200 MHz clock.
`default_nettype none
module tb_usb_core_ctrl_status_irq;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o, rd;
	logic pready_o, pslverr_o, err, addr_match_o;
	logic resume_drive_o, suspended_o, host_role_o, irq_o;
	ucsi_pkg::ucsi_line_t line;
	ucsi_pkg::ucsi_token_t token;
	int miscompares = 0;
	int checked = 0;
	int ev[5] = '{6, 5, 4, 3, 2};
	localparam logic [7:0] C0 = ucsi_pkg::CSR0_OFS;
	localparam logic [7:0] EV = ucsi_pkg::EVT_OFS;
	localparam logic [7:0] CF = ucsi_pkg::CFG_OFS;
	always #2.5 clk_i = ~clk_i;
	ucsi_core dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .line_i(line), .token_i(token),
		.addr_match_o(addr_match_o), .resume_drive_o(resume_drive_o),
		.suspended_o(suspended_o), .host_role_o(host_role_o), .irq_o(irq_o));
	ucsi_cable_model pm (.clk_i(clk_i), .line_o(line), .token_o(token));
	////////////////////////////////////////////////////////////////////
	task automatic check(input string s, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", s, e, g);
		end
	endtask : check
	// One APB transfer; waits for pready, never assumes a count
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, e,
		input string s);
		apb(1'b0, a, 32'h0);
		check(s, e, rd & m);
	endtask : rdc
	task automatic print_verdict();
		$display("checked %0d, miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////////
	// Hang guard, well past the expected run length
	initial begin
		#50000;
		miscompares++;
		print_verdict();
	end
	initial begin
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rdc(C0, '1, 32'h0, "ctrl0");
		rdc(EV, '1, 32'h0600_0000, "events");
		check("mapped err", 32'h0, {31'h0, err});
		check("irq", 32'h0, {31'h0, irq_o});
		apb(1'b0, 8'h0c, 32'h0);
		check("unmapped", 32'h1, {31'h0, err});
		$display("reset test done");
		apb(1'b1, C0, 32'h100);
		pm.pulse(1);
		#1 check("susp", 32'h1, {31'h0, suspended_o});
		rdc(C0, '1, 32'h300, "ctrl0");
		apb(1'b1, C0, 32'h500);
		#1 check("resume", 32'h1, {31'h0, resume_drive_o});
		// Hold cut to a few cycles; the 10 ms wait is software's part
		apb(1'b1, C0, 32'h100);
		#1 check("resume", 32'h0, {31'h0, resume_drive_o});
		pm.pulse(0);
		#1 check("susp", 32'h0, {31'h0, suspended_o});
		rdc(EV, '1, 32'h0601_0000, "susp flag");
		apb(1'b1, C0, 32'h0);
		pm.pulse(1);
		#1 check("blocked", 32'h0, {31'h0, suspended_o});
		// Allow only turns on with this write; its old zero value, not the role, keeps the status bit clear
		apb(1'b1, C0, 32'h300);
		rdc(C0, '1, 32'h100, "dev wr");
		apb(1'b1, CF, 32'h1);
		#1 check("role", 32'h1, {31'h0, host_role_o});
		apb(1'b1, C0, 32'h300);
		#1 check("host set", 32'h1, {31'h0, suspended_o});
		apb(1'b1, C0, 32'h700);
		#1 check("host resume", 32'h1, {31'h0, resume_drive_o});
		// Hold cut to a few cycles; the 20 ms wait is software's part
		apb(1'b1, C0, 32'h300);
		#1 check("host resume", 32'h0, {31'h0, resume_drive_o});
		pm.pulse(2);
		#1 check("hw clr", 32'h0, {31'h0, suspended_o});
		rdc(EV, 32'h0002_0000, 32'h0002_0000, "res flag");
		$display("suspend test done");
		// Host-role events, each enabled, sticky until the read
		apb(1'b1, EV, 32'hff00_0000);
		foreach (ev[i]) begin
			// Line struct bit sits one above the event index
			pm.pulse(ev[i] + 1);
			repeat (3) @(posedge clk_i);
			#1 check("irq", 32'h1, {31'h0, irq_o});
			rdc(EV, '1, 32'hff00_0000 | (32'h1 << (ev[i] + 16)), "ev");
			#1 check("irq", 32'h0, {31'h0, irq_o});
		end
		apb(1'b1, EV, 32'h0);
		pm.pulse(4);
		#1 check("masked", 32'h0, {31'h0, irq_o});
		apb(1'b1, EV, 32'h0800_0000);
		#1 check("unmask", 32'h1, {31'h0, irq_o});
		pm.level(8, 1'b1);
		pm.level(9, 1'b1);
		pm.level(9, 1'b0);
		rdc(EV, 32'h0080_0000, 32'h0080_0000, "vbus");
		apb(1'b1, CF, 32'h0);
		pm.level(8, 1'b0);
		repeat (3) @(posedge clk_i);
		rdc(EV, 32'h0020_0000, 32'h0020_0000, "sess end");
		$display("event test done");
		apb(1'b1, C0, 32'h7f);
		pm.token(7'h7f);
		#1 check("match", 32'h1, {31'h0, addr_match_o});
		pm.token(7'h7e);
		#1 check("miss", 32'h0, {31'h0, addr_match_o});
		$display("address test done");
		// Reset again in mid-run: enables and fields must come back
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rdc(EV, '1, 32'h0600_0000, "rerun events");
		rdc(C0, '1, 32'h0, "rerun ctrl0");
		$display("reset rerun done");
		print_verdict();
	end
endmodule : tb_usb_core_ctrl_status_irq
`default_nettype wire
